// File: common/mitb_consts.svh
// Offsets, field positions, reset values and counts of the interrupt and time base block
`ifndef MITB_CONSTS_SVH
`define MITB_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MITB_OFS_PSC0 8'h00
`define MITB_OFS_PSC1 8'h01
`define MITB_OFS_TBC0 8'h02
`define MITB_OFS_TBC1 8'h03
`define MITB_OFS_CTRL 8'h04
`define MITB_OFS_MEN 8'h05
`define MITB_OFS_MFLG 8'h06
`define MITB_OFS_TMEN 8'h07
`define MITB_OFS_TMFLG 8'h08
`define MITB_OFS_XEN 8'h09
`define MITB_OFS_XFLG 8'h0a

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define MITB_TB_EN_BIT 7
`define MITB_GIE_BIT 0
`define MITB_REG_RST 8'h00
`define MITB_TB_MIN 16'h0100
`define MITB_DIV4_LAST 2'h3
`define MITB_NUM_TIMERS 3

`endif

// File: common/mitb_pkg.sv
// Types shared by the interrupt and time base block
`default_nettype none

package mitb_pkg;

    // Vector numbers; a lower number wins when several are pending
    typedef enum logic [2:0] {
        vec_serial = 3'h0,
        vec_uart0 = 3'h1,
        vec_uart1 = 3'h2,
        vec_period0 = 3'h3,
        vec_period1 = 3'h4,
        vec_group0 = 3'h5,
        vec_group1 = 3'h6,
        vec_group2 = 3'h7
    } mitb_vec_t;

    // Prescaler clock source codes
    typedef enum logic [1:0] {
        psc_sys = 2'h0,
        psc_div4 = 2'h1,
        psc_sub = 2'h2
    } mitb_psc_t;

endpackage

`default_nettype wire

// File: core/mitb_top.sv
// Interrupt flags, vectoring, wake-up and the two time base generators
//
// Function
// - Two-bit source select: sys, sys/4, sub
// - Unimplemented select and control bits read zero
// - Time base 0 counts only when enabled
// - Period0 is two to eight-plus-field ticks
// - Time base 1 identical on prescaler 1
// - Timer modules: A and P flags, enables
// - Timer vector needs global, source, group enable
// - Timer service clears global and group only
// - Serial flag on byte, address, timeout
// - Serial service clears its flag, global
// - UART flag on any UART condition
// - UART service clears flag and global only
// - Low supply flag through group, software clears
// - EEPROM done flag through its group
// - Any flag rising wakes from sleep
// - Flags stay set until serviced or cleared
// - No vector while the stack is full
// - Only program counter is pushed
// - Period overflow sets its own flag
// - Return from interrupt sets global enable
`include "mitb_consts.svh"
`default_nettype none

module mitb_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Sub clock, asynchronous
    input wire logic sub_clk,
    // Peripheral event pulses
    input wire logic [2:0] timer_match_a,
    input wire logic [2:0] timer_match_p,
    input wire logic [2:0] serial_module_event,
    input wire logic [5:0] uart0_event,
    input wire logic [5:0] uart1_event,
    input wire logic low_supply_event,
    input wire logic eeprom_done_event,
    // Processor core
    input wire logic stack_full,
    input wire logic vector_ack,
    input wire logic return_from_irq,
    input wire logic sleep_mode,
    output logic irq_req,
    output logic [2:0] irq_vector,
    output logic wake_up
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic psc_tick(input logic [1:0] sel, input logic d4, input logic sb);
        return sel[1] ? sb : (sel == 2'(mitb_pkg::psc_div4) ? d4 : 1'b1);
    endfunction

    function automatic logic [14:0] period_last(input logic [2:0] len);
        logic [15:0] span;
        span = 16'(`MITB_TB_MIN << len);
        return 15'(span - 16'h0001);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [1:0] psc_sel_reg [2];
    logic tb_en_reg [2];
    logic [2:0] tb_len_reg [2];
    logic [14:0] tb_cnt_reg [2];
    logic [14:0] tb_cnt_next [2];
    logic tb_tick [2];
    logic tb_ovf [2];
    logic [1:0] div4_cnt_reg;
    logic sub_s1_reg;
    logic sub_s2_reg;
    logic sub_s3_reg;
    logic gie_reg;
    logic gie_next;
    logic [7:0] men_reg;
    logic [7:0] mflg_reg;
    logic [7:0] mflg_next;
    logic [5:0] tmen_reg;
    logic [5:0] tmflg_reg;
    logic [5:0] tmflg_next;
    logic [1:0] xen_reg;
    logic [1:0] xflg_reg;
    logic [1:0] xflg_next;
    logic [2:0] grp_prev_reg;
    logic [15:0] all_prev_reg;
    logic irq_req_reg;
    logic [2:0] irq_vector_reg;
    logic wake_reg;
    logic [7:0] reg_rdata_reg;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire wr_psc0 = reg_wr && reg_addr == `MITB_OFS_PSC0;
    wire wr_psc1 = reg_wr && reg_addr == `MITB_OFS_PSC1;
    wire wr_tbc0 = reg_wr && reg_addr == `MITB_OFS_TBC0;
    wire wr_tbc1 = reg_wr && reg_addr == `MITB_OFS_TBC1;
    wire wr_ctrl = reg_wr && reg_addr == `MITB_OFS_CTRL;
    wire wr_men = reg_wr && reg_addr == `MITB_OFS_MEN;
    wire wr_mflg = reg_wr && reg_addr == `MITB_OFS_MFLG;
    wire wr_tmen = reg_wr && reg_addr == `MITB_OFS_TMEN;
    wire wr_tmflg = reg_wr && reg_addr == `MITB_OFS_TMFLG;
    wire wr_xen = reg_wr && reg_addr == `MITB_OFS_XEN;
    wire wr_xflg = reg_wr && reg_addr == `MITB_OFS_XFLG;

    // ----------------------------------------
    // Prescaler sources
    // ----------------------------------------
    wire div4_tick = div4_cnt_reg == `MITB_DIV4_LAST;
    // Sub clock is sampled, so it must run well below clk/2
    wire sub_tick = sub_s2_reg && !sub_s3_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div4_cnt_reg <= 2'h0;
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            sub_s3_reg <= 1'b0;
        end else begin
            div4_cnt_reg <= div4_cnt_reg + 2'h1;
            sub_s1_reg <= sub_clk;
            sub_s2_reg <= sub_s1_reg;
            sub_s3_reg <= sub_s2_reg;
        end
    end

    // ----------------------------------------
    // Time bases
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            tb_tick[i] = psc_tick(psc_sel_reg[i], div4_tick, sub_tick);
            tb_ovf[i] = tb_en_reg[i] && tb_tick[i]
                && tb_cnt_reg[i] == period_last(tb_len_reg[i]);
            tb_cnt_next[i] = tb_cnt_reg[i];
            if (!tb_en_reg[i]) begin
                tb_cnt_next[i] = 15'h0000;
            end else if (tb_ovf[i]) begin
                tb_cnt_next[i] = 15'h0000;
            end else if (tb_tick[i]) begin
                tb_cnt_next[i] = tb_cnt_reg[i] + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                tb_cnt_reg[i] <= 15'h0000;
                psc_sel_reg[i] <= 2'h0;
                tb_en_reg[i] <= 1'b0;
                tb_len_reg[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                tb_cnt_reg[i] <= tb_cnt_next[i];
            end
            if (wr_psc0) begin
                psc_sel_reg[0] <= reg_wdata[1:0];
            end
            if (wr_psc1) begin
                psc_sel_reg[1] <= reg_wdata[1:0];
            end
            if (wr_tbc0) begin
                tb_en_reg[0] <= reg_wdata[`MITB_TB_EN_BIT];
                tb_len_reg[0] <= reg_wdata[2:0];
            end
            if (wr_tbc1) begin
                tb_en_reg[1] <= reg_wdata[`MITB_TB_EN_BIT];
                tb_len_reg[1] <= reg_wdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // Request flags
    // ----------------------------------------
    wire ack_take = vector_ack && irq_req;
    wire [7:0] ack_mask = ack_take ? 8'(8'h01 << irq_vector_reg) : 8'h00;
    wire [5:0] timer_set = {timer_match_p, timer_match_a};
    // Group flag follows a new enabled source request
    wire [2:0] grp_lvl = {
        xflg_reg[1] && xen_reg[1],
        xflg_reg[0] && xen_reg[0],
        |(tmflg_reg & tmen_reg)
    };
    wire [2:0] grp_set = grp_lvl & ~grp_prev_reg;
    wire [7:0] main_set = {
        grp_set,
        tb_ovf[1],
        tb_ovf[0],
        |uart1_event,
        |uart0_event,
        |serial_module_event
    };
    wire [7:0] mflg_base = wr_mflg ? reg_wdata : mflg_reg;
    wire [15:0] all_flags = {xflg_reg, tmflg_reg, mflg_reg};

    // Hardware set wins over service clear and over software clear
    assign mflg_next = (mflg_base & ~ack_mask) | main_set;
    // Source flags are never touched by servicing
    assign tmflg_next = (wr_tmflg ? reg_wdata[5:0] : tmflg_reg) | timer_set;
    assign xflg_next = (wr_xflg ? reg_wdata[1:0] : xflg_reg)
        | {eeprom_done_event, low_supply_event};

    assign gie_next = ack_take ? 1'b0 : return_from_irq ? 1'b1 :
        wr_ctrl ? reg_wdata[`MITB_GIE_BIT] : gie_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gie_reg <= 1'b0;
            men_reg <= `MITB_REG_RST;
            mflg_reg <= `MITB_REG_RST;
            tmen_reg <= 6'h00;
            tmflg_reg <= 6'h00;
            xen_reg <= 2'h0;
            xflg_reg <= 2'h0;
            grp_prev_reg <= 3'h0;
        end else begin
            gie_reg <= gie_next;
            mflg_reg <= mflg_next;
            tmflg_reg <= tmflg_next;
            xflg_reg <= xflg_next;
            grp_prev_reg <= grp_lvl;
            if (wr_men) begin
                men_reg <= reg_wdata;
            end
            if (wr_tmen) begin
                tmen_reg <= reg_wdata[5:0];
            end
            if (wr_xen) begin
                xen_reg <= reg_wdata[1:0];
            end
        end
    end

    // ----------------------------------------
    // Vectoring
    // ----------------------------------------
    wire [7:0] pending = mflg_reg & men_reg;
    logic [2:0] vec_pick;

    always_comb begin
        vec_pick = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pending[i]) begin
                vec_pick = 3'(i);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_req_reg <= 1'b0;
            irq_vector_reg <= 3'h0;
        end else begin
            irq_req_reg <= |pending && !ack_take;
            irq_vector_reg <= vec_pick;
        end
    end

    // Gating by live enable and stack stops a second take after an ack
    assign irq_req = irq_req_reg && gie_reg && !stack_full;
    assign irq_vector = irq_vector_reg;

    // ----------------------------------------
    // Wake-up
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            all_prev_reg <= 16'h0000;
            wake_reg <= 1'b0;
        end else begin
            all_prev_reg <= all_flags;
            wake_reg <= sleep_mode && |(all_flags & ~all_prev_reg);
        end
    end

    assign wake_up = wake_reg;

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    wire [7:0] rd_mux =
        reg_addr == `MITB_OFS_PSC0 ? {6'h00, psc_sel_reg[0]} :
        reg_addr == `MITB_OFS_PSC1 ? {6'h00, psc_sel_reg[1]} :
        reg_addr == `MITB_OFS_TBC0 ? {tb_en_reg[0], 4'h0, tb_len_reg[0]} :
        reg_addr == `MITB_OFS_TBC1 ? {tb_en_reg[1], 4'h0, tb_len_reg[1]} :
        reg_addr == `MITB_OFS_CTRL ? {7'h00, gie_reg} :
        reg_addr == `MITB_OFS_MEN ? men_reg :
        reg_addr == `MITB_OFS_MFLG ? mflg_reg :
        reg_addr == `MITB_OFS_TMEN ? {2'h0, tmen_reg} :
        reg_addr == `MITB_OFS_TMFLG ? {2'h0, tmflg_reg} :
        reg_addr == `MITB_OFS_XEN ? {6'h00, xen_reg} :
        reg_addr == `MITB_OFS_XFLG ? {6'h00, xflg_reg} : 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= 8'h00;
        end else begin
            reg_rdata_reg <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_psc_read_zero;
        reg_rd && reg_addr == `MITB_OFS_PSC0 |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_psc_read_zero: assert property (p_psc_read_zero)
        else $error("prescaler select upper bits not zero");
    property p_div4_tick;
        tb_en_reg[0] && psc_sel_reg[0] == 2'h1 && tb_tick[0] |-> div4_cnt_reg == `MITB_DIV4_LAST;
    endproperty
    a_div4_tick: assert property (p_div4_tick)
        else $error("divided source ticked off its phase");
    property p_off_clears;
        !tb_en_reg[1] |=> tb_cnt_reg[1] == 15'h0000;
    endproperty
    a_off_clears: assert property (p_off_clears)
        else $error("disabled period counter not at zero");
    property p_ovf_at_last;
        tb_ovf[0] |-> tb_cnt_reg[0] == period_last(tb_len_reg[0]) && tb_en_reg[0];
    endproperty
    a_ovf_at_last: assert property (p_ovf_at_last)
        else $error("period overflow at wrong count");
    property p_ovf_flag;
        tb_ovf[1] |=> mflg_reg[4] ##1 mflg_reg[4] || $past(ack_take) || $past(wr_mflg);
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("period overflow did not set its flag");
    // Full stack must refuse the vector yet keep the request pending
    property p_stack_block;
        stack_full && (|pending) && !wr_mflg && !wr_men |-> !irq_req ##1 (|pending);
    endproperty
    a_stack_block: assert property (p_stack_block)
        else $error("vector offered or request lost with full stack");
    property p_ack_gie;
        vector_ack && irq_req |=> !gie_reg && !irq_req;
    endproperty
    a_ack_gie: assert property (p_ack_gie)
        else $error("global enable kept after service");
    property p_return_from_irq;
        return_from_irq && !ack_take |=> gie_reg;
    endproperty
    a_return_from_irq: assert property (p_return_from_irq)
        else $error("return did not restore global enable");
    property p_sticky;
        mflg_reg[5] && !ack_take && !wr_mflg |=> mflg_reg[5];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("group flag lost without clear");
    property p_wake;
        sleep_mode && |(all_flags & ~all_prev_reg) |=> wake_up;
    endproperty
    a_wake: assert property (p_wake)
        else $error("flag rise did not wake");
    property p_tm_kept;
        ack_take && tmflg_reg != 6'h00 && !wr_tmflg |=> tmflg_reg != 6'h00;
    endproperty
    a_tm_kept: assert property (p_tm_kept)
        else $error("service cleared a source flag");

    c_take_group0: cover property (ack_take && irq_vector_reg == 3'h5);
    c_period_ovf: cover property (tb_ovf[0] && tb_len_reg[0] == 3'h0);
    c_wake: cover property (wake_up);
    c_stack_hold: cover property (irq_req_reg && gie_reg && stack_full);

endmodule

`default_nettype wire

// File: tb/mitb_core_model.sv
// Behavioural processor core that takes vectored calls from the block
`default_nettype none

module mitb_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench controls
    input wire logic ack_en,
    input wire logic do_return_from_irq,
    input wire logic [3:0] stack_limit,
    // Block side
    input wire logic irq_req,
    input wire logic [2:0] irq_vector,
    output logic vector_ack,
    output logic return_from_irq,
    output logic stack_full,
    // Observation
    output logic [2:0] taken_vec,
    output int n_taken
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Call stack and service routine
    // ----------------------------------------
    logic [3:0] depth;
    logic [3:0] svc_cnt;
    logic in_svc;

    // A limit of zero fakes a full stack
    assign stack_full = (depth >= stack_limit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vector_ack <= 1'b0;
            return_from_irq <= 1'b0;
            taken_vec <= 3'h0;
            n_taken <= 0;
            depth <= 4'h0;
            svc_cnt <= 4'h0;
            in_svc <= 1'b0;
        end else begin
            vector_ack <= 1'b0;
            return_from_irq <= 1'b0;
            if (irq_req && ack_en && !vector_ack && !in_svc) begin
                vector_ack <= 1'b1;
                taken_vec <= irq_vector;
            end
            if (vector_ack) begin
                depth <= depth + 4'h1;
                in_svc <= 1'b1;
                svc_cnt <= 4'h0;
                n_taken <= n_taken + 1;
            end else if (in_svc) begin
                svc_cnt <= svc_cnt + 4'h1;
                // Routine makes no calls, so one stack level is enough
                if (svc_cnt == 4'h7) begin
                    in_svc <= 1'b0;
                    depth <= depth - 4'h1;
                    return_from_irq <= do_return_from_irq;
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the interrupt and time base block
`include "mitb_consts.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk, rst, sub_clk, reg_wr, reg_rd, sleep_mode, ack_en, do_return_from_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [22:0] ev;
    logic [3:0] stack_limit;
    logic vector_ack, return_from_irq, stack_full, irq_req, wake_up;
    logic [2:0] irq_vector, taken_vec;
    int n_fail = 0;
    int n_checks = 0;
    int n_wake = 0;
    int n_taken;

    mitb_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sub_clk(sub_clk),
        .timer_match_a(ev[17:15]), .timer_match_p(ev[20:18]), .serial_module_event(ev[2:0]),
        .uart0_event(ev[8:3]), .uart1_event(ev[14:9]), .low_supply_event(ev[21]),
        .eeprom_done_event(ev[22]), .stack_full(stack_full), .vector_ack(vector_ack),
        .return_from_irq(return_from_irq), .sleep_mode(sleep_mode), .irq_req(irq_req),
        .irq_vector(irq_vector), .wake_up(wake_up));

    mitb_core_model core (.clk(clk), .rst(rst), .ack_en(ack_en), .do_return_from_irq(do_return_from_irq),
        .stack_limit(stack_limit), .irq_req(irq_req), .irq_vector(irq_vector),
        .vector_ack(vector_ack), .return_from_irq(return_from_irq),
        .stack_full(stack_full), .taken_vec(taken_vec), .n_taken(n_taken));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Sub clock of eight system cycles, phase unrelated
    initial begin
        sub_clk = 1'b0;
        #7;
        forever #80 sub_clk = ~sub_clk;
    end

    always @(posedge clk) begin
        if (wake_up === 1'b1) n_wake++;
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic give_up(input string w);
        n_fail++;
        $display("mismatch at %0t: no %s in time", $time, w);
        wrap_up();
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string w);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, w);
    endtask

    task automatic pulse(input logic [22:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 23'h0;
    endtask

    task automatic wait_irq(input int lim, output int cyc);
        for (cyc = 0; irq_req !== 1'b1; cyc++) begin
            if (cyc == lim) give_up("request");
            @(posedge clk);
            #1;
        end
    endtask

    task automatic quiet(input int n, input string w);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk({7'h0, irq_req}, 8'h00, w);
        end
    endtask

    task automatic take(input logic [2:0] vec);
        int prev;
        int i;
        prev = n_taken;
        for (i = 0; n_taken == prev; i++) begin
            if (i == 40) give_up("vector");
            @(posedge clk);
        end
        chk({5'h0, taken_vec}, {5'h0, vec}, "taken vector");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        int a;
        for (a = 0; a < 12; a++) rchk(8'(a), `MITB_REG_RST, "reset value");
        wr(`MITB_OFS_PSC0, 8'hff);
        wr(`MITB_OFS_PSC1, 8'hff);
        wr(`MITB_OFS_TBC0, 8'h7f);
        wr(`MITB_OFS_TBC1, 8'h7f);
        wr(8'h0b, 8'hff);
        rchk(`MITB_OFS_PSC0, 8'h03, "select 0 bits");
        rchk(`MITB_OFS_PSC1, 8'h03, "select 1 bits");
        rchk(`MITB_OFS_TBC0, 8'h07, "control 0 bits");
        rchk(`MITB_OFS_TBC1, 8'h07, "control 1 bits");
        rchk(8'h0b, 8'h00, "unmapped read");
    endtask

    // Enable, disable half way, enable again: a full period must follow
    task automatic t_period(input logic [7:0] psc, input logic [7:0] tbc,
            input logic [1:0] sel, input logic [2:0] len, input int unit, input logic [2:0] vec);
        int cyc;
        int exp;
        exp = unit << (8 + len);
        wr(psc, {6'h0, sel});
        wr(tbc, {5'h10, len});
        repeat (exp / 2) @(posedge clk);
        wr(tbc, {5'h0, len});
        wr(tbc, {5'h10, len});
        wait_irq(exp + 64, cyc);
        chk({7'h0, cyc >= exp - unit && cyc <= exp + 3 * unit + 4}, 8'h01, "period");
        chk({5'h0, irq_vector}, {5'h0, vec}, "period vector");
        wr(tbc, 8'h00);
        wr(`MITB_OFS_MFLG, 8'h00);
    endtask

    task automatic t_gate();
        int c;
        wr(`MITB_OFS_TMEN, 8'h3e);
        pulse(23'h1 << 15);
        quiet(6, "source disabled");
        rchk(`MITB_OFS_TMFLG, 8'h01, "timer flag");
        rchk(`MITB_OFS_MFLG, 8'h00, "group flag");
        wr(`MITB_OFS_TMFLG, 8'h00);
        wr(`MITB_OFS_TMEN, 8'h3f);
        wr(`MITB_OFS_MEN, 8'hfe);
        stack_limit <= 4'h0;
        pulse(23'h04001);
        quiet(6, "held off");
        wr(`MITB_OFS_MEN, 8'hff);
        quiet(4, "stack full");
        stack_limit <= 4'hc;
        wait_irq(8, c);
        chk({5'h0, irq_vector}, 8'h00, "priority");
        ack_en <= 1'b1;
        take(3'h0);
        wr(`MITB_OFS_CTRL, 8'h01);
        take(3'h2);
        wr(`MITB_OFS_CTRL, 8'h01);
    endtask

    // Every event bit of every source, serviced with a plain return
    task automatic t_service();
        int k;
        logic [2:0] vec;
        logic [7:0] tf;
        logic [7:0] xf;
        for (k = 0; k < 23; k++) begin
            vec = k < 3 ? 3'h0 : k < 9 ? 3'h1 : k < 15 ? 3'h2 : k < 21 ? 3'h5 : k == 21 ? 3'h6 : 3'h7;
            tf = (k >= 15 && k < 21) ? 8'h01 << (k - 15) : 8'h00;
            xf = k >= 21 ? 8'h01 << (k - 21) : 8'h00;
            pulse(23'h1 << k);
            take(vec);
            repeat (10) @(posedge clk);
            rchk(`MITB_OFS_CTRL, 8'h00, "global cleared");
            rchk(`MITB_OFS_MFLG, 8'h00, "own flag cleared");
            rchk(`MITB_OFS_TMFLG, tf, "timer flag kept");
            rchk(`MITB_OFS_XFLG, xf, "extra flag kept");
            wr(`MITB_OFS_TMFLG, 8'h00);
            wr(`MITB_OFS_XFLG, 8'h00);
            wr(`MITB_OFS_CTRL, 8'h01);
        end
    endtask

    task automatic t_return_from_irq();
        do_return_from_irq <= 1'b1;
        pulse(23'h1 << 22);
        take(3'h7);
        repeat (12) @(posedge clk);
        rchk(`MITB_OFS_CTRL, 8'h01, "global restored");
        rchk(`MITB_OFS_XFLG, 8'h02, "done flag kept");
        wr(`MITB_OFS_XFLG, 8'h00);
    endtask

    // Global and extra enables off: wake-up must not depend on them
    task automatic t_wake();
        int w;
        ack_en <= 1'b0;
        wr(`MITB_OFS_CTRL, 8'h00);
        wr(`MITB_OFS_XEN, 8'h00);
        wr(`MITB_OFS_XFLG, 8'h02);
        repeat (3) @(posedge clk);
        sleep_mode <= 1'b1;
        w = n_wake;
        pulse(23'h1 << 22);
        repeat (4) @(posedge clk);
        chk(8'(n_wake - w), 8'h00, "preset flag");
        pulse(23'h1 << 21);
        repeat (4) @(posedge clk);
        chk(8'(n_wake - w), 8'h01, "wake on rise");
        sleep_mode <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ev = 23'h0;
        sleep_mode = 1'b0;
        ack_en = 1'b0;
        do_return_from_irq = 1'b0;
        stack_limit = 4'hc;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        wr(`MITB_OFS_CTRL, 8'h01);
        wr(`MITB_OFS_MEN, 8'hff);
        wr(`MITB_OFS_TMEN, 8'h3f);
        wr(`MITB_OFS_XEN, 8'h03);
        t_period(`MITB_OFS_PSC0, `MITB_OFS_TBC0, 2'h0, 3'h0, 1, 3'h3);
        t_period(`MITB_OFS_PSC0, `MITB_OFS_TBC0, 2'h1, 3'h1, 4, 3'h3);
        t_period(`MITB_OFS_PSC0, `MITB_OFS_TBC0, 2'h2, 3'h0, 8, 3'h3);
        t_period(`MITB_OFS_PSC1, `MITB_OFS_TBC1, 2'h3, 3'h0, 8, 3'h4);
        t_period(`MITB_OFS_PSC1, `MITB_OFS_TBC1, 2'h0, 3'h7, 1, 3'h4);
        t_gate();
        t_service();
        t_return_from_irq();
        t_wake();
        wrap_up();
    end
endmodule

`default_nettype wire
